// [rie_exec.sv]
// Return-from-interrupt and return-literal execution unit
`include "rie_cfg.svh"
// Behaviour
// RQ1 - Interrupt return pops stack into PC, takes two cycles, second idle.
// RQ2 - Interrupt return sets high or low global enable in the pop quarter.
// RQ3 - Shadow bit set restores accumulator, flags and bank select from shadows.
// RQ4 - Shadow bit clear leaves them alone; PC latches never change here.
// RQ5 - Literal return loads literal to accumulator, pops stack, two cycles.
module rie_exec import rie_pkg::*; #(
    parameter int PCW = 21
) (
    input  wire logic           ref_clk,
    input  wire logic           nrst,
    input  wire logic [15:0]    instr_word,
    input  wire logic           instr_valid,
    input  wire logic [PCW-1:0] stack_top_entry,
    input  wire logic [7:0]     accumulator_shadow,
    input  wire logic [4:0]     flags_shadow,
    input  wire logic [3:0]     bank_select_shadow,
    input  wire logic           prio_mode_en,
    input  wire logic           ret_low_prio,
    input  wire logic           irq_vector_high,
    input  wire logic           irq_vector_low,
    input  wire logic           latch_wr,
    input  wire logic [4:0]     latch_upper_data,
    input  wire logic [7:0]     latch_high_data,
    output logic                decode_ready,
    output logic                busy,
    output logic                stack_pop,
    output logic [PCW-1:0]      program_counter,
    output logic [7:0]          accumulator,
    output logic [4:0]          flags_register,
    output logic [3:0]          bank_select_register,
    output logic                global_high_priority_irq_enable,
    output logic                low_priority_irq_enable,
    output logic [4:0]          pc_upper_latch,
    output logic [7:0]          pc_high_latch
);
    // ************************************
    // Quarter phases
    // ************************************
    logic [`RIE_QPHASES-1:0] phase;

    rie_qphase #(
        .N(`RIE_QPHASES)
    ) u_qphase (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .phase   (phase)
    );

    logic first_phase;
    logic fourth_quarter_phase;
    assign first_phase          = phase[0];
    assign fourth_quarter_phase = phase[`RIE_FOURTH_PHASE];

    // ************************************
    // Decode
    // ************************************
    logic       is_irq_ret;
    logic       is_lit_ret;
    logic       accept;
    rie_state_t state_q;
    rie_state_t state_d;

    // Only the two return patterns are taken; anything else is ignored
    assign is_irq_ret = (instr_word & `RIE_IRQRET_MASK) == `RIE_IRQRET_MATCH;
    assign is_lit_ret = (instr_word & `RIE_LITRET_MASK) == `RIE_LITRET_MATCH;
    assign decode_ready = (state_q == RIE_IDLE) && first_phase;
    assign accept       = decode_ready && instr_valid && (is_irq_ret || is_lit_ret);
    assign busy         = state_q != RIE_IDLE;
    assign stack_pop    = (state_q == RIE_EXEC) && fourth_quarter_phase; // RQ1

    // ************************************
    // Sequencer and operand capture
    // ************************************
    rie_op_t    op_q;
    rie_op_t    op_d;
    logic       shadow_q;
    logic       shadow_d;
    logic [7:0] lit_q;
    logic [7:0] lit_d;

    // Decode quarter starts the first cycle; the whole second cycle is idle
    always_comb begin
        state_d  = state_q;
        op_d     = op_q;
        shadow_d = shadow_q;
        lit_d    = lit_q;
        unique case (state_q)
            RIE_IDLE: begin
                if (accept) begin
                    state_d  = RIE_EXEC; // RQ1
                    op_d     = is_irq_ret ? RIE_OP_IRQ : RIE_OP_LIT;
                    shadow_d = is_irq_ret && instr_word[`RIE_SHADOW_BIT];
                    lit_d    = instr_word[`RIE_LIT_MSB:`RIE_LIT_LSB]; // RQ5
                end
            end
            RIE_EXEC: begin
                if (fourth_quarter_phase) begin
                    state_d = RIE_FLUSH; // RQ1
                end
            end
            RIE_FLUSH: begin
                if (fourth_quarter_phase) begin
                    state_d = RIE_IDLE; // RQ1
                end
            end
            default: begin
                state_d = RIE_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_q  <= RIE_IDLE;
            op_q     <= RIE_OP_IRQ;
            shadow_q <= 1'b0;
            lit_q    <= 8'h00;
        end else begin
            state_q  <= state_d;
            op_q     <= op_d;
            shadow_q <= shadow_d;
            lit_q    <= lit_d;
        end
    end

    // ************************************
    // Architectural registers
    // ************************************
    logic [PCW-1:0] pc_q;
    logic [PCW-1:0] pc_d;
    logic [7:0]     acc_q;
    logic [7:0]     acc_d;
    logic [4:0]     flags_q;
    logic [4:0]     flags_d;
    logic [3:0]     bank_q;
    logic [3:0]     bank_d;
    logic           hpen_q;
    logic           hpen_d;
    logic           lpen_q;
    logic           lpen_d;
    logic [4:0]     upper_q;
    logic [4:0]     upper_d;
    logic [7:0]     high_q;
    logic [7:0]     high_d;
    logic           pop_irq;
    logic           pop_lit;

    assign pop_irq = stack_pop && (op_q == RIE_OP_IRQ);
    assign pop_lit = stack_pop && (op_q == RIE_OP_LIT);

    // Return updates land in the fourth quarter of the first cycle; vector clears and latch writes land on any edge
    always_comb begin
        pc_d    = pc_q;
        acc_d   = acc_q;
        flags_d = flags_q;
        bank_d  = bank_q;
        hpen_d  = hpen_q;
        lpen_d  = lpen_q;
        upper_d = upper_q;
        high_d  = high_q;
        // Vectoring clears the enable; a return in the same edge wins
        if (irq_vector_high) begin
            hpen_d = 1'b0;
        end
        if (irq_vector_low) begin
            lpen_d = 1'b0;
        end
        if (stack_pop) begin
            pc_d = stack_top_entry; // RQ1
        end
        if (pop_irq) begin
            // Low enable only when priorities are on and a low handler returns
            if (prio_mode_en && ret_low_prio) begin
                lpen_d = 1'b1; // RQ2
            end else begin
                hpen_d = 1'b1; // RQ2
            end
            if (shadow_q) begin
                acc_d   = accumulator_shadow; // RQ3
                flags_d = flags_shadow;       // RQ3
                bank_d  = bank_select_shadow; // RQ3
            end
        end
        if (pop_lit) begin
            acc_d = lit_q; // RQ5
        end
        // Latch writes come only from the core port, never from a return
        if (latch_wr) begin
            upper_d = latch_upper_data; // RQ4
            high_d  = latch_high_data;  // RQ4
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pc_q    <= `RIE_PC_RST;
            acc_q   <= `RIE_ACC_RST;
            flags_q <= `RIE_FLAGS_RST;
            bank_q  <= `RIE_BANK_RST;
            hpen_q  <= 1'b0;
            lpen_q  <= 1'b0;
            upper_q <= `RIE_UPPER_RST;
            high_q  <= `RIE_HIGH_RST;
        end else begin
            pc_q    <= pc_d;
            acc_q   <= acc_d;
            flags_q <= flags_d;
            bank_q  <= bank_d;
            hpen_q  <= hpen_d;
            lpen_q  <= lpen_d;
            upper_q <= upper_d;
            high_q  <= high_d;
        end
    end

    assign program_counter                 = pc_q;
    assign accumulator                     = acc_q;
    assign flags_register                  = flags_q;
    assign bank_select_register            = bank_q;
    assign global_high_priority_irq_enable = hpen_q;
    assign low_priority_irq_enable         = lpen_q;
    assign pc_upper_latch                  = upper_q;
    assign pc_high_latch                   = high_q;

    // ************************************
    // Checks
    // ************************************
    sequence pop_then_pc;
        stack_pop ##1 (pc_q == $past(stack_top_entry));
    endsequence

    sequence two_cycle_busy;
        busy [*7] ##1 (!busy && decode_ready);
    endsequence

    pop_fourth_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ1
        (accept && is_irq_ret) |-> ##3 pop_then_pc)
        else $error("return did not pop the stack into the PC in the fourth quarter");

    two_cycles_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ1
        accept |=> two_cycle_busy)
        else $error("return did not occupy exactly two instruction cycles");

    irq_enable_set_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ2
        pop_irq |=> ($past(prio_mode_en && ret_low_prio) ? lpen_q : hpen_q))
        else $error("global enable not set on the pop edge");

    shadow_restore_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ3
        (pop_irq && shadow_q) |=> (acc_q == $past(accumulator_shadow)) &&
            (flags_q == $past(flags_shadow)) && (bank_q == $past(bank_select_shadow)))
        else $error("shadow copies not restored");

    no_restore_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ4
        (pop_irq && !shadow_q) |=> $stable(acc_q) && $stable(flags_q) && $stable(bank_q))
        else $error("registers changed without shadow restore");

    latch_stable_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ4
        (stack_pop && !latch_wr) |=> $stable(upper_q) && $stable(high_q))
        else $error("PC latches changed on a return");

    literal_load_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ5
        (accept && is_lit_ret) |-> ##3 (stack_pop ##1
            (acc_q == $past(instr_word[7:0], 4)) && (pc_q == $past(stack_top_entry))))
        else $error("literal return did not load accumulator and PC");

    flush_idle_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RQ1
        (state_q == RIE_FLUSH) |-> !stack_pop ##1 $stable(pc_q))
        else $error("second cycle was not idle");
endmodule : rie_exec

// [rie_cfg.svh]
// Constants for the return-from-interrupt execution block
`ifndef RIE_CFG_SVH
`define RIE_CFG_SVH
// Instruction encodings (mask and match value)
`define RIE_IRQRET_MASK    16'hFFFE
`define RIE_IRQRET_MATCH   16'h0010
`define RIE_LITRET_MASK    16'hFF00
`define RIE_LITRET_MATCH   16'h0C00
// Field positions inside the instruction word
`define RIE_SHADOW_BIT     0
`define RIE_LIT_MSB        7
`define RIE_LIT_LSB        0
// Timing counts
`define RIE_QPHASES        4
`define RIE_INSTR_CYCLES   2
`define RIE_FOURTH_PHASE   3
// Reset values
`define RIE_PC_RST         21'h000000
`define RIE_ACC_RST        8'h00
`define RIE_FLAGS_RST      5'h00
`define RIE_BANK_RST       4'h0
`define RIE_UPPER_RST      5'h00
`define RIE_HIGH_RST       8'h00
`endif

// [rie_pkg.sv]
// Types for the return-from-interrupt execution block
package rie_pkg;
    // Execution state, one-hot
    typedef enum logic [2:0] {
        RIE_IDLE  = 3'b001,
        RIE_EXEC  = 3'b010,
        RIE_FLUSH = 3'b100
    } rie_state_t;
    // Kind of return being executed, one-hot
    typedef enum logic [1:0] {
        RIE_OP_IRQ = 2'b01,
        RIE_OP_LIT = 2'b10
    } rie_op_t;
endpackage : rie_pkg

// [rie_qphase.sv]
// Quarter-phase sequencer of the instruction cycle
`include "rie_cfg.svh"
module rie_qphase import rie_pkg::*; #(
    parameter int N = `RIE_QPHASES
) (
    input  wire logic         ref_clk,
    input  wire logic         nrst,
    output logic [N-1:0]      phase
);
    // ************************************
    // Phase ring
    // ************************************
    logic [N-1:0] phase_q;
    logic [N-1:0] phase_d;

    // Rotate one hot bit; reset lands on the first quarter
    always_comb begin
        phase_d = {phase_q[N-2:0], phase_q[N-1]};
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            phase_q <= {{(N-1){1'b0}}, 1'b1};
        end else begin
            phase_q <= phase_d;
        end
    end

    assign phase = phase_q;
endmodule : rie_qphase

// [rie_testbench.sv]
// Self-checking bench for the interrupt and literal return execution unit
`include "rie_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import rie_pkg::*;
    logic        ref_clk, nrst, instr_valid, prio_mode_en, ret_low_prio;
    logic        irq_vector_high, irq_vector_low, latch_wr;
    logic [15:0] instr_word;
    logic [20:0] stack_top_entry;
    logic [7:0]  accumulator_shadow, latch_high_data;
    logic [4:0]  flags_shadow, latch_upper_data;
    logic [3:0]  bank_select_shadow;
    logic        decode_ready, busy, stack_pop, hi_en, lo_en;
    logic [20:0] program_counter;
    logic [7:0]  accumulator, pc_high_latch;
    logic [4:0]  flags_register, pc_upper_latch;
    logic [3:0]  bank_select_register;
    logic [31:0] seed = 32'h7319;
    logic [31:0] e_pc, e_acc, e_flg, e_bank, e_hi, e_lo, e_up, e_hl;
    int          n_mismatch = 0;
    int          checks = 0;
    int          cyc = 0;
    int          pops = 0;
    rie_exec #(.PCW(21)) dut (.ref_clk(ref_clk), .nrst(nrst), .instr_word(instr_word),
        .instr_valid(instr_valid), .stack_top_entry(stack_top_entry),
        .accumulator_shadow(accumulator_shadow), .flags_shadow(flags_shadow),
        .bank_select_shadow(bank_select_shadow), .prio_mode_en(prio_mode_en), .ret_low_prio(ret_low_prio),
        .irq_vector_high(irq_vector_high), .irq_vector_low(irq_vector_low), .latch_wr(latch_wr),
        .latch_upper_data(latch_upper_data), .latch_high_data(latch_high_data), .decode_ready(decode_ready),
        .busy(busy), .stack_pop(stack_pop), .program_counter(program_counter), .accumulator(accumulator),
        .flags_register(flags_register), .bank_select_register(bank_select_register),
        .global_high_priority_irq_enable(hi_en), .low_priority_irq_enable(lo_en),
        .pc_upper_latch(pc_upper_latch), .pc_high_latch(pc_high_latch));
    // ****************************************
    // Clock, reset and hang guard
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // A generous ceiling: every test ends within a few hundred cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch = n_mismatch + 1;
            stop_test();
        end
    end
    // Next pseudo-random word, Galois form
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
    endfunction : lfsr
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks = checks + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask : step
    // Compare every architectural output with the bench model
    task automatic cmp_all();
        chk("stack_pop", 0, {31'h0, stack_pop});
        chk("busy", 0, {31'h0, busy});
        chk("program_counter", e_pc, {11'h0, program_counter});
        chk("accumulator", e_acc, {24'h0, accumulator});
        chk("flags_register", e_flg, {27'h0, flags_register});
        chk("bank_select_register", e_bank, {28'h0, bank_select_register});
        chk("high_enable", e_hi, {31'h0, hi_en});
        chk("low_enable", e_lo, {31'h0, lo_en});
        chk("pc_upper_latch", e_up, {27'h0, pc_upper_latch});
        chk("pc_high_latch", e_hl, {24'h0, pc_high_latch});
    endtask : cmp_all
    // Issue one word with random operands; expect execution only for return patterns
    task automatic issue(input logic [15:0] w, input logic pm, input logic lp);
        int n;
        logic irq, lit;
        irq = ((w & `RIE_IRQRET_MASK) == `RIE_IRQRET_MATCH);
        lit = ((w & `RIE_LITRET_MASK) == `RIE_LITRET_MATCH);
        seed = lfsr(seed);
        {stack_top_entry, accumulator_shadow[2:0]} = seed[23:0];
        seed = lfsr(seed);
        {accumulator_shadow[7:3], flags_shadow, bank_select_shadow} = seed[13:0];
        prio_mode_en = pm;
        ret_low_prio = lp;
        n = 0;
        while (decode_ready !== 1'b1 && n < 10) begin
            step();
            n = n + 1;
        end
        instr_word = w;
        instr_valid = 1'b1;
        step();
        instr_valid = 1'b0;
        chk("busy", {31'h0, irq | lit}, {31'h0, busy});
        n = 0;
        while (stack_pop !== 1'b1 && n < 6) begin
            step();
            n = n + 1;
        end
        chk("pop_seen", {31'h0, irq | lit}, {31'h0, stack_pop});
        if (irq | lit) begin
            chk("pop_quarter", `RIE_FOURTH_PHASE - 1, n);
            e_pc = stack_top_entry;
            if (lit) e_acc = w[`RIE_LIT_MSB:`RIE_LIT_LSB];
            if (irq && pm && lp) e_lo = 1;
            else if (irq) e_hi = 1;
            if (irq && w[`RIE_SHADOW_BIT]) begin
                e_acc = accumulator_shadow;
                e_flg = flags_shadow;
                e_bank = bank_select_shadow;
            end
            step();
            n = n + 1;
            while (decode_ready !== 1'b1 && n < 12) begin
                step();
                n = n + 1;
            end
            chk("cycles", `RIE_INSTR_CYCLES * `RIE_QPHASES - 1, n);
        end
        cmp_all();
        $display("test word %h done", w);
    endtask : issue
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {nrst, instr_valid, prio_mode_en, ret_low_prio, irq_vector_high, irq_vector_low, latch_wr} = 7'h00;
        {instr_word, stack_top_entry, accumulator_shadow, flags_shadow, bank_select_shadow} = 54'h0;
        {latch_upper_data, latch_high_data} = 13'h0;
        {e_pc, e_acc, e_flg, e_bank, e_hi, e_lo, e_up, e_hl} = 256'h0;
        repeat (12) @(posedge ref_clk);
        #1 nrst = 1'b1;
        cmp_all();
        // Latches only move on their own write strobe
        seed = lfsr(seed);
        {latch_upper_data, latch_high_data} = seed[12:0];
        latch_wr = 1'b1;
        step();
        latch_wr = 1'b0;
        e_up = latch_upper_data;
        e_hl = latch_high_data;
        // Every shadow and priority combination, with both enables cleared before each
        for (int i = 0; i < 8; i++) begin
            irq_vector_high = 1'b1;
            irq_vector_low = 1'b1;
            step();
            {irq_vector_high, irq_vector_low} = 2'b00;
            e_hi = 0;
            e_lo = 0;
            issue(16'h0010 | i[0], i[1], i[2]);
        end
        // Back-to-back literal returns with random literals
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            issue({8'h0C, seed[7:0]}, 1'b0, 1'b0);
        end
        issue(16'h0CFF, 1'b1, 1'b1);
        // Neighbouring words 0012, 0013 and 0110 are not returns from interrupt; 0011 is one
        issue(16'h0012, 1'b0, 1'b0);
        issue(16'h0013, 1'b0, 1'b0);
        issue(16'h0110, 1'b0, 1'b0);
        issue(16'h0011, 1'b0, 1'b0);
        // A second word held valid while busy must be ignored
        instr_word = 16'h0C5A;
        instr_valid = 1'b1;
        step();
        instr_word = 16'h0C33;
        for (int k = 0; k < 12; k++) begin
            if (k == 6) instr_valid = 1'b0;
            pops = pops + stack_pop;
            step();
        end
        e_pc = stack_top_entry;
        e_acc = 8'h5A;
        chk("busy_refused_pop", 1, pops);
        cmp_all();
        stop_test();
    end
endmodule : testbench
